/* File: cfg_loader_map.vh */
`ifndef CFG_LOADER_MAP_VH
`define CFG_LOADER_MAP_VH
// serial clock periods in ns
`define SCLK_PERIOD_SLOW_NS 4000
`define SCLK_PERIOD_FAST_NS 800
// system clock period in ns
`define CLK_PERIOD_NS 20
// half period counts in system clocks, rounded down, at least one
`define HALF_SLOW ((`SCLK_PERIOD_SLOW_NS / `CLK_PERIOD_NS) / 2)
`define HALF_FAST ((`SCLK_PERIOD_FAST_NS / `CLK_PERIOD_NS) / 2)
// bus speed field encodings
`define SPEED_25MHZ 2'h3
`define SPEED_125MHZ 2'h0
// serial read command: start bit, read opcode
`define READ_CMD 3'h6
`define ADDR_W 6
`define WORD_W 16
`define WORD_CNT 7'h40
`define BIT_CNT_W 5
`define CMD_BITS 5'h09
// data bits per word and the count value that marks the last one
`define WORD_BITS 5'h10
`define LAST_BIT 5'h01
`define FIFO_DEPTH 8
`endif

/* File: cfg_word_fifo.v */
`timescale 1ns/1ps
module cfg_word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  // output register refills whenever it is empty or drained
  wire pop = !empty && (!o_out_valid || i_out_ready);
  wire push = i_in_valid && !full;
  assign o_in_ready = !full;
  always @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        o_out_data <= mem[rd_ptr_r[AW-1:0]];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule

/* File: cfg_mem_loader.v */
`timescale 1ns/1ps
`include "cfg_loader_map.vh"
module cfg_mem_loader (
  input wire i_clock,
  input wire i_nrst,
  input wire [1:0] i_onchip_bus_speed_ctl,
  input wire i_cfg_mem_sdata,
  output reg o_cfg_mem_sdata,
  output reg o_cfg_mem_sdata_oe,
  input wire i_cfg_mem_sclk,
  output reg o_cfg_mem_sclk,
  output reg o_cfg_mem_sclk_oe,
  output reg o_cfg_mem_select,
  output reg o_mem_present,
  output reg o_big_endian,
  output reg o_busy,
  output reg o_done,
  output reg o_word_valid,
  input wire i_word_ready,
  output reg [`WORD_W-1:0] o_word_data,
  output reg [`ADDR_W-1:0] o_word_addr
);
  localparam ST_STRAP = 6'h01;
  localparam ST_IDLE = 6'h02;
  localparam ST_CMD = 6'h04;
  localparam ST_DATA = 6'h08;
  localparam ST_PUSH = 6'h10;
  localparam ST_GAP = 6'h20;
  localparam HALF_SLOW = `HALF_SLOW;
  localparam HALF_FAST = `HALF_FAST;
  reg [5:0] state_r;
  reg [6:0] div_r;
  reg [6:0] half_r;
  reg [`BIT_CNT_W-1:0] bit_r;
  reg [`ADDR_W:0] addr_r;
  reg [`WORD_W-1:0] shift_r;
  reg [`ADDR_W+2:0] cmd_r;
  reg strap_done_r;
  wire fifo_ready;
  wire fifo_valid;
  wire [`WORD_W-1:0] fifo_data;
  // bus speed picks the half period; other codes fall back to the slow rate
  always @* begin
    if (i_onchip_bus_speed_ctl == `SPEED_125MHZ) begin
      half_r = HALF_FAST[6:0];
    end else begin
      half_r = HALF_SLOW[6:0];
    end
  end
  wire tick = (div_r == half_r - 7'h01);
  wire rise = tick && !o_cfg_mem_sclk;
  wire fall = tick && o_cfg_mem_sclk;
  // sequencer: command shift, then sixteen data bits per word
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r <= ST_STRAP;
      div_r <= 7'h00;
      bit_r <= {`BIT_CNT_W{1'b0}};
      addr_r <= {(`ADDR_W+1){1'b0}};
      shift_r <= {`WORD_W{1'b0}};
      cmd_r <= {(`ADDR_W+3){1'b0}};
      strap_done_r <= 1'b0;
      o_cfg_mem_sdata <= 1'b0;
      o_cfg_mem_sdata_oe <= 1'b0;
      o_cfg_mem_sclk <= 1'b0;
      o_cfg_mem_sclk_oe <= 1'b0;
      o_cfg_mem_select <= 1'b0;
      o_mem_present <= 1'b0;
      o_big_endian <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      case (state_r)
        ST_STRAP: begin
          // pins still released here, so the pull levels are what we see
          o_mem_present <= i_cfg_mem_sdata;
          o_big_endian <= i_cfg_mem_sclk;
          strap_done_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          o_cfg_mem_sclk_oe <= 1'b1;
          if (o_mem_present && !o_done) begin
            o_busy <= 1'b1;
            o_cfg_mem_select <= 1'b1;
            o_cfg_mem_sdata_oe <= 1'b1;
            cmd_r <= {`READ_CMD, addr_r[`ADDR_W-1:0]};
            bit_r <= `CMD_BITS;
            div_r <= 7'h00;
            state_r <= ST_CMD;
          end else begin
            o_done <= 1'b1;
            o_busy <= 1'b0;
          end
        end
        ST_CMD: begin
          div_r <= tick ? 7'h00 : div_r + 7'h01;
          if (tick) begin
            o_cfg_mem_sclk <= !o_cfg_mem_sclk;
          end
          // data changes on the falling edge, memory samples on rising
          if (fall || (div_r == 7'h00 && bit_r == `CMD_BITS && !o_cfg_mem_sclk)) begin
            if (bit_r == {`BIT_CNT_W{1'b0}}) begin
              o_cfg_mem_sdata_oe <= 1'b0;
              bit_r <= `WORD_BITS;
              state_r <= ST_DATA;
            end else begin
              o_cfg_mem_sdata <= cmd_r[`ADDR_W+2];
              cmd_r <= {cmd_r[`ADDR_W+1:0], 1'b0};
              bit_r <= bit_r - 1'b1;
            end
          end
        end
        ST_DATA: begin
          div_r <= tick ? 7'h00 : div_r + 7'h01;
          if (tick) begin
            o_cfg_mem_sclk <= !o_cfg_mem_sclk;
          end
          if (rise) begin
            shift_r <= {shift_r[`WORD_W-2:0], i_cfg_mem_sdata};
            bit_r <= bit_r - 1'b1;
            if (bit_r == `LAST_BIT) begin
              state_r <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          // waits here while the fifo is full, holding the clock low
          if (fall || !o_cfg_mem_sclk) begin
            o_cfg_mem_sclk <= 1'b0;
            if (fifo_ready) begin
              o_cfg_mem_select <= 1'b0;
              addr_r <= addr_r + 1'b1;
              state_r <= ST_GAP;
            end
          end else begin
            div_r <= tick ? 7'h00 : div_r + 7'h01;
          end
        end
        ST_GAP: begin
          // deselect lasts two system clocks between words: div_r still holds the tick count, so this state ends at once
          div_r <= tick ? 7'h00 : div_r + 7'h01;
          if (tick) begin
            div_r <= 7'h00;
            // address counter is one bit wider so the end count fits
            if (addr_r == `WORD_CNT) begin
              o_done <= 1'b1;
              o_busy <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // word lands in the fifo at the falling clock after the last bit, or later once the fifo has room
  wire push = (state_r == ST_PUSH) && (fall || !o_cfg_mem_sclk);
  cfg_word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(shift_r),
    .o_out_valid(fifo_valid),
    .i_out_ready(i_word_ready && o_word_valid || !o_word_valid),
    .o_out_data(fifo_data)
  );
  // output stage registered so every port comes from a flip-flop
  reg [`ADDR_W-1:0] out_addr_r;
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_word_valid <= 1'b0;
      o_word_data <= {`WORD_W{1'b0}};
      o_word_addr <= {`ADDR_W{1'b0}};
      out_addr_r <= {`ADDR_W{1'b0}};
    end else if (!o_word_valid || i_word_ready) begin
      o_word_valid <= fifo_valid;
      o_word_data <= fifo_data;
      if (o_word_valid) begin
        out_addr_r <= out_addr_r + 1'b1;
      end
      o_word_addr <= (o_word_valid) ? out_addr_r + 1'b1 : out_addr_r;
    end
  end
endmodule

/* File: cfg_eeprom_model.sv */
`timescale 1ns/1ps
module cfg_eeprom_model (
  input wire i_sclk,
  input wire i_select,
  input wire i_sdata,
  output reg o_drive,
  output reg o_data,
  output reg o_cmd_err
);
  reg [8:0] cmd_r;
  reg [15:0] word_r;
  integer n;
  initial begin
    o_drive = 0;
    o_data = 0;
    o_cmd_err = 0;
    n = 0;
  end
  // new frame on each select rise
  always @(posedge i_select) n = 0;
  // command bits in on rising clock, then the word is fetched
  always @(posedge i_sclk) if (i_select) begin
    if (n < 9) cmd_r = {cmd_r[7:0], i_sdata};
    n = n + 1;
    if (n == 9) begin
      o_cmd_err = o_cmd_err | (cmd_r[8:6] !== 3'b110);
      word_r = {2'b10, cmd_r[5:0], 2'b01, ~cmd_r[5:0]};
    end
  end
  // reply bits change on falling clock, msb first
  always @(negedge i_sclk) begin
    o_drive = i_select && n >= 9 && n < 25;
    if (o_drive) o_data = word_r[24 - n];
  end
  // line let go at deselect so the pull shows
  always @(negedge i_select) o_drive = 0;
endmodule

/* File: cfg_loader_sva.sv */
`timescale 1ns/1ps
`include "cfg_loader_map.vh"
module cfg_loader_sva (
  input wire i_clock,
  input wire i_nrst,
  input wire [1:0] i_onchip_bus_speed_ctl,
  input wire i_cfg_mem_sdata,
  input wire i_cfg_mem_sclk,
  input wire o_cfg_mem_sclk,
  input wire o_cfg_mem_sdata_oe,
  input wire o_cfg_mem_select,
  input wire o_mem_present,
  input wire o_big_endian,
  input wire o_done,
  input wire o_word_valid,
  input wire i_word_ready,
  input wire [`WORD_W-1:0] o_word_data,
  input wire [`ADDR_W-1:0] o_word_addr
);
  reg prev_r;
  integer run_r;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // length of the current sclk level in block clocks
  always @(posedge i_clock) begin
    prev_r <= o_cfg_mem_sclk;
    if (!i_nrst || o_cfg_mem_sclk != prev_r) run_r <= 1;
    else run_r <= run_r + 1;
  end
  sequence s_strap; $rose(i_nrst); endsequence
  sequence s_no_mem; s_strap ##0 !i_cfg_mem_sdata; endsequence
  a_strap_mem: assert property (s_strap |=> o_mem_present == $past(i_cfg_mem_sdata))
    else $error("memory strap wrong");
  a_strap_order: assert property (s_strap |=> o_big_endian == $past(i_cfg_mem_sclk))
    else $error("byte order strap wrong");
  a_skip_done: assert property (s_no_mem |-> ##[1:4] o_done)
    else $error("skip did not finish");
  a_no_mem_quiet: assert property (!o_mem_present |-> !o_cfg_mem_select && !o_cfg_mem_sdata_oe)
    else $error("access without memory");
  a_oe_select: assert property (o_cfg_mem_sdata_oe |-> o_cfg_mem_select)
    else $error("data driven while unselected");
  a_sclk_frame: assert property (o_cfg_mem_sclk |-> o_cfg_mem_select)
    else $error("clock high while unselected");
  a_sclk_high: assert property ($fell(o_cfg_mem_sclk) |-> run_r ==
    (i_onchip_bus_speed_ctl == 2'h0 ? `HALF_FAST : `HALF_SLOW))
    else $error("clock half period wrong");
  a_word_hold: assert property (o_word_valid && !i_word_ready |=>
    o_word_valid && $stable(o_word_data) && $stable(o_word_addr))
    else $error("word dropped before taken");
  a_done_holds: assert property (o_done |=> o_done)
    else $error("done fell");
endmodule

/* File: serial_eeprom_config_loader_tb.sv */
`timescale 1ns/1ps
module serial_eeprom_config_loader_tb;
  logic i_clock = 0, i_nrst = 0, i_word_ready = 0, pull_d = 0, pull_c = 0;
  logic [1:0] i_onchip_bus_speed_ctl = 2'h0;
  wire i_cfg_mem_sdata, i_cfg_mem_sclk, o_cfg_mem_sdata, o_cfg_mem_sdata_oe, o_cfg_mem_sclk;
  wire o_cfg_mem_sclk_oe, o_cfg_mem_select, o_mem_present, o_big_endian, o_busy, o_done;
  wire o_word_valid, m_drv, m_dat, m_err;
  wire [15:0] o_word_data;
  wire [5:0] o_word_addr;
  integer errors = 0, compares = 0, cyc = 0;
  // pin levels: driver first, else the pull resistor
  assign i_cfg_mem_sdata = o_cfg_mem_sdata_oe ? o_cfg_mem_sdata : (m_drv ? m_dat : pull_d);
  assign i_cfg_mem_sclk = o_cfg_mem_sclk_oe ? o_cfg_mem_sclk : pull_c;
  cfg_mem_loader DUT (.*);
  cfg_eeprom_model mem (.i_sclk(o_cfg_mem_sclk), .i_select(o_cfg_mem_select),
    .i_sdata(i_cfg_mem_sdata), .o_drive(m_drv), .o_data(m_dat), .o_cmd_err(m_err));
  always #10 i_clock = ~i_clock;
  // hang guard, well above the expected run of about 74k cycles
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (cyc == 98000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rst(input pd, input pc, input [1:0] sp);
    begin
      i_nrst <= 1'b0;
      pull_d <= pd;
      pull_c <= pc;
      i_onchip_bus_speed_ctl <= sp;
      repeat (4) @(posedge i_clock);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_clock);
    end
  endtask
  task take(input integer n);
    integer k;
    begin
      k = 0;
      while (k < n) begin
        @(posedge i_clock);
        if (o_word_valid === 1'b1 && i_word_ready) begin
          chk(o_word_data, {2'b10, k[5:0], 2'b01, ~k[5:0]});
          chk(o_word_addr, k[5:0]);
          k = k + 1;
        end
      end
    end
  endtask
  // full fast load, reader stalled first while nine words queue, one short of filling the fifo
  task t_load;
    begin
      rst(1'b1, 1'b1, 2'h0);
      chk(o_mem_present, 1'b1);
      chk(o_big_endian, 1'b1);
      repeat (10000) @(posedge i_clock);
      chk(o_busy, 1'b1);
      chk(o_cfg_mem_sclk_oe, 1'b1);
      chk(o_cfg_mem_select, 1'b1);
      i_word_ready <= 1'b1;
      take(64);
      repeat (4) @(posedge i_clock);
      chk(o_done, 1'b1);
      chk(m_err, 1'b0);
      $display("fast load test done");
    end
  endtask
  // slow rate, cut short by the next reset
  task t_slow;
    begin
      rst(1'b1, 1'b0, 2'h3);
      chk(o_big_endian, 1'b0);
      take(2);
      $display("slow load test done");
    end
  endtask
  // no memory strapped: defaults kept, no access
  task t_skip;
    begin
      rst(1'b0, 1'b1, 2'h1);
      repeat (4) @(posedge i_clock);
      chk(o_mem_present, 1'b0);
      chk(o_done, 1'b1);
      chk(o_cfg_mem_select, 1'b0);
      chk(o_busy, 1'b0);
      chk(o_cfg_mem_sdata_oe, 1'b0);
      $display("skip test done");
    end
  endtask
  task wrap_up;
    begin
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    t_load;
    t_slow;
    t_skip;
    wrap_up;
  end
endmodule
bind cfg_mem_loader cfg_loader_sva u_sva (.*);
